// >>> src/power_mode_pkg.sv
// Constants for the flash power-mode control block
package power_mode_pkg;
    localparam logic [7:0] SLEEP_OPCODE_DEFAULT  = 8'hb9;
    localparam logic [7:0] WAKE_OPCODE_DEFAULT   = 8'hab;
    localparam logic [7:0] STATUS_RESET_VALUE    = 8'h00;
    localparam logic [7:0] ARRAY_ERASED_VALUE    = 8'hff;
    localparam logic [1:0] LOCK_RESET_VALUE      = 2'b00;
    localparam int         CLK_PERIOD_PS         = 5000;
    // Times as printed, with derived cycle counts
    localparam int         SUPPLY_SELECT_US      = 30;
    localparam int         POWERUP_WRITE_MS      = 1;
    localparam int         SLEEP_ENTRY_NS        = 3000;
    localparam int         WAKE_NS               = 30000;
    localparam int         SUPPLY_SELECT_CYCLES  =
        (SUPPLY_SELECT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int         POWERUP_WRITE_CYCLES  =
        (POWERUP_WRITE_MS * 1000000000 / 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS * 1000;
    localparam int         SLEEP_ENTRY_CYCLES    =
        (SLEEP_ENTRY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int         WAKE_CYCLES           =
        (WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int         CNT_W                 = 24;
    localparam logic [3:0] BIT_COUNT_RESET       = 4'h0;
    typedef enum logic [1:0] {
        MODE_STANDBY  = 2'b00,
        MODE_ENTERING = 2'b01,
        MODE_SLEEP    = 2'b10,
        MODE_WAKING   = 2'b11
    } power_mode_t;
endpackage : power_mode_pkg

// >>> src/flash_power_mode_control.sv
// Deep-sleep, power-up and write-inhibit control of a serial flash
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1: Deep sleep entered only by entry opcode; writes ignored while asleep.
// RQ2: Select high with no cycle running gives ordinary standby.
// RQ3: Host sends only wake opcode while device sleeps.
// RQ4: Reset ends sleep; device always starts in standby.
// RQ5: Entry executes only if select rises right after eighth bit.
// RQ6: After valid entry, wait entry delay before sleeping.
// RQ7: Entry opcode during a running cycle is discarded.
// RQ8: Asleep, only wake opcode is decoded; it leaves sleep.
// RQ9: Extra clock edges after wake opcode reject it.
// RQ10: Wake reaches standby after wake delay; host keeps select high.
// RQ11: Wake opcode during a running cycle is discarded.
// RQ12: Power-on reset holds all logic reset, answers nothing.
// RQ13: Write-class opcodes ignored until write-inhibit delay expires.
// RQ14: Host waits later of write delay and select delay.
// RQ15: Reads allowed once select delay passed.
// RQ16: Host keeps select high around supply ramps.
// RQ17: Power-up clears write latch, cycle flag, lock pairs.
// RQ18: Delivery state: array reads ones, status reads zeros.
// RQ19: Cycle running while active flag is one; clears on completion.
// RQ20: Opcodes are parameters, MSB first, rising clock sampled.
// RQ21: Delays are parameterised cycle counts.
module flash_power_mode_control
    import power_mode_pkg::*;
#(
    parameter logic [7:0] SLEEP_OPCODE   = SLEEP_OPCODE_DEFAULT,
    parameter logic [7:0] WAKE_OPCODE    = WAKE_OPCODE_DEFAULT,
    parameter int         SLEEP_DLY      = SLEEP_ENTRY_CYCLES,
    parameter int         WAKE_DLY       = WAKE_CYCLES,
    parameter int         POWERUP_DLY    = POWERUP_WRITE_CYCLES,
    parameter int         SELECT_DLY     = SUPPLY_SELECT_CYCLES,
    parameter int         SECTORS        = 4
) (
    // Clock and power-on reset
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    // Serial link pins
    input  wire logic               select_b,
    input  wire logic               serial_clk,
    input  wire logic               serial_in_line,
    // Self-timed cycle engine
    input  wire logic               cycle_done,
    input  wire logic               cycle_start,
    input  wire logic               write_permit_cmd,
    input  wire logic               write_permit_clear,
    // Mode and status
    output logic                    deep_sleep,
    output logic                    write_cycle_active,
    output logic                    write_permit_latch,
    output logic                    writes_allowed,
    output logic                    reads_allowed,
    output logic                    cmd_accept,
    output logic [7:0]              status_value,
    output logic [7:0]              erased_value,
    output logic [2*SECTORS-1:0]    lock_bits
);
    initial begin
        if (SLEEP_DLY < 1 || WAKE_DLY < 1 || POWERUP_DLY < 1 ||
            SELECT_DLY < 1 || POWERUP_DLY >= 2**CNT_W ||
            SLEEP_DLY >= 2**CNT_W || WAKE_DLY >= 2**CNT_W ||
            SELECT_DLY >= 2**CNT_W || SECTORS < 1)
            $error("flash_power_mode_control: bad parameter");
    end

    // Two-flop synchronisers for the link pins
    logic [1:0] sel_sync_reg;
    logic [1:0] clk_sync_reg;
    logic [1:0] din_sync_reg;
    logic       clk_prev_reg;
    logic       sel_prev_reg;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_sync_reg <= 2'b11;
            clk_sync_reg <= 2'b00;
            din_sync_reg <= 2'b00;
            clk_prev_reg <= 1'b0;
            sel_prev_reg <= 1'b1;
        end else begin
            sel_sync_reg <= {sel_sync_reg[0], select_b};
            clk_sync_reg <= {clk_sync_reg[0], serial_clk};
            din_sync_reg <= {din_sync_reg[0], serial_in_line};
            clk_prev_reg <= clk_sync_reg[1];
            sel_prev_reg <= sel_sync_reg[1];
        end
    end

    logic clk_rise;
    logic sel_rise;
    assign clk_rise = clk_sync_reg[1] & ~clk_prev_reg & ~sel_sync_reg[1];
    assign sel_rise = sel_sync_reg[1] & ~sel_prev_reg;

    // Opcode shifter, MSB first on rising serial clock
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_reg   <= 8'h00;
            bit_cnt_reg <= BIT_COUNT_RESET;
        end else if (sel_sync_reg[1]) begin
            bit_cnt_reg <= BIT_COUNT_RESET;
        end else if (clk_rise) begin
            shift_reg <= {shift_reg[6:0], din_sync_reg[1]}; // see RQ20
            if (bit_cnt_reg != 4'hf)
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    // Exactly eight bits when select rises; extra edges reject
    logic exact8;
    logic sleep_hit;
    logic wake_hit;
    assign exact8    = sel_rise && bit_cnt_reg == 4'h8; // see RQ5 see RQ9
    assign sleep_hit = exact8 && shift_reg == SLEEP_OPCODE;
    assign wake_hit  = exact8 && shift_reg == WAKE_OPCODE;

    // Power-up delay counters
    logic [CNT_W-1:0] pu_cnt_reg;
    logic [CNT_W-1:0] sel_cnt_reg;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pu_cnt_reg  <= '0;
            sel_cnt_reg <= '0;
        end else begin
            if (!writes_allowed)
                pu_cnt_reg <= pu_cnt_reg + 1'b1; // see RQ13 see RQ21
            if (!reads_allowed)
                sel_cnt_reg <= sel_cnt_reg + 1'b1; // see RQ15
        end
    end
    assign writes_allowed = pu_cnt_reg >= CNT_W'(POWERUP_DLY);
    assign reads_allowed  = sel_cnt_reg >= CNT_W'(SELECT_DLY);

    // Power mode machine
    power_mode_t      mode_reg;
    logic [CNT_W-1:0] dly_reg;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg <= MODE_STANDBY; // see RQ4 see RQ12
            dly_reg  <= '0;
        end else begin
            case (mode_reg)
                MODE_STANDBY: begin
                    if (sleep_hit && !write_cycle_active) begin // see RQ7
                        mode_reg <= MODE_ENTERING; // see RQ1 see RQ6
                        dly_reg  <= '0;
                    end
                end
                MODE_ENTERING: begin
                    dly_reg <= dly_reg + 1'b1;
                    if (dly_reg >= CNT_W'(SLEEP_DLY - 1))
                        mode_reg <= MODE_SLEEP;
                end
                MODE_SLEEP: begin
                    if (wake_hit && !write_cycle_active) begin // see RQ11
                        mode_reg <= MODE_WAKING; // see RQ8
                        dly_reg  <= '0;
                    end
                end
                MODE_WAKING: begin
                    dly_reg <= dly_reg + 1'b1;
                    if (dly_reg >= CNT_W'(WAKE_DLY - 1))
                        mode_reg <= MODE_STANDBY; // see RQ10
                end
                default: mode_reg <= MODE_STANDBY;
            endcase
        end
    end
    assign deep_sleep = mode_reg == MODE_SLEEP;

    // Commands pass only in standby with select delay met
    assign cmd_accept = mode_reg == MODE_STANDBY && reads_allowed; // see RQ2

    // Write latch and cycle flag, cleared at power-up
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            write_permit_latch <= 1'b0; // see RQ17
            write_cycle_active <= 1'b0;
        end else begin
            if (write_permit_cmd && cmd_accept && writes_allowed &&
                !write_cycle_active) // see RQ1 see RQ13
                write_permit_latch <= 1'b1;
            else if (write_permit_clear)
                write_permit_latch <= 1'b0;
            if (cycle_start && cmd_accept && writes_allowed)
                write_cycle_active <= 1'b1;
            else if (cycle_done)
                write_cycle_active <= 1'b0; // see RQ19
        end
    end

    // Lock pairs and delivery values
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_bits    <= {SECTORS{LOCK_RESET_VALUE}}; // see RQ17
            status_value <= STATUS_RESET_VALUE; // see RQ18
            erased_value <= ARRAY_ERASED_VALUE;
        end else begin
            status_value <= {6'h00, write_permit_latch, write_cycle_active};
        end
    end

    // Cycles spent waking; bounds the wake delay check below
    logic [CNT_W-1:0] wake_age_reg;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            wake_age_reg <= '0;
        else if (mode_reg == MODE_WAKING)
            wake_age_reg <= wake_age_reg + 1'b1;
        else
            wake_age_reg <= '0;
    end

    sleep_entry_delay_a: assert property (@(posedge core_clk) // see RQ6
        disable iff (!rst_b) (mode_reg == MODE_STANDBY && sleep_hit &&
        !write_cycle_active) |=> !deep_sleep [*1] ##0 (mode_reg ==
        MODE_ENTERING)) else $error("sleep entry skipped delay");
    busy_sleep_drop_a: assert property (@(posedge core_clk) // see RQ7
        disable iff (!rst_b) (mode_reg == MODE_STANDBY && write_cycle_active)
        |=> mode_reg != MODE_ENTERING) else $error("entry while busy");
    sleep_only_wake_a: assert property (@(posedge core_clk) // see RQ8
        disable iff (!rst_b) (deep_sleep && !wake_hit) |=> deep_sleep)
        else $error("sleep left without wake");
    sleep_no_cmd_a: assert property (@(posedge core_clk) // see RQ1
        disable iff (!rst_b) deep_sleep |-> !cmd_accept)
        else $error("command accepted asleep");
    wake_reaches_a: assert property (@(posedge core_clk) // see RQ10
        disable iff (!rst_b) (mode_reg == MODE_WAKING) |->
        wake_age_reg < CNT_W'(WAKE_DLY))
        else $error("wake delay overran");
    extra_edge_a: assert property (@(posedge core_clk) // see RQ9
        disable iff (!rst_b) (sel_rise && bit_cnt_reg != 4'h8) |=>
        $stable(mode_reg)) else $error("bad length acted");
    write_gate_a: assert property (@(posedge core_clk) // see RQ13
        disable iff (!rst_b) !writes_allowed |=> !write_permit_latch)
        else $error("write permit too early");
    cycle_clear_a: assert property (@(posedge core_clk) // see RQ19
        disable iff (!rst_b) (cycle_done && !(cycle_start && cmd_accept &&
        writes_allowed)) |=> !write_cycle_active)
        else $error("active flag stuck");
    wake_busy_a: assert property (@(posedge core_clk) // see RQ11
        disable iff (!rst_b) (deep_sleep && write_cycle_active) |=> deep_sleep)
        else $error("wake while busy");
    sleep_cov_c: cover property (@(posedge core_clk) $rose(deep_sleep));
    wake_cov_c: cover property (@(posedge core_clk) $fell(deep_sleep));
    write_cov_c: cover property (@(posedge core_clk) $rose(writes_allowed));
endmodule : flash_power_mode_control
`default_nettype wire

// >>> bench/spi_host_model.sv
// Serial host model that shifts opcodes into the power-mode block
`timescale 1ns/1ps
`default_nettype none
module spi_host_model #(
    parameter int HALF_NS = 24
) (
    // Serial link pins
    output logic select_b,
    output logic serial_clk,
    output logic serial_in_line
);
    // Idle: deselected, clock parked low
    initial begin
        select_b       = 1'b1;
        serial_clk     = 1'b0;
        serial_in_line = 1'b0;
    end
    // Shift n bits MSB first with select held low throughout
    task automatic send(input logic [15:0] word, input int n);
        select_b = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in_line = word[i];
            #(HALF_NS) serial_clk = 1'b1;
            #(HALF_NS) serial_clk = 1'b0;
        end
        #(HALF_NS) select_b = 1'b1;
        // Released line must not keep showing the last bit
        serial_in_line = ~serial_in_line;
    endtask : send
endmodule : spi_host_model
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the flash power-mode control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import power_mode_pkg::*;
    localparam int SDLY = 20;
    localparam int WDLY = 30;
    localparam int SELD = 50;
    localparam int PUD  = 100;
    // Clock, reset and block pins
    logic       core_clk = 1'b0;
    logic       rst_b, cyc_done, cyc_start, wp_cmd, wp_clr;
    logic       select_b, serial_clk, serial_in_line;
    logic       deep_sleep, wca, wpl, wr_ok, rd_ok, cmd_accept;
    logic [7:0] status_value, erased_value, lock_bits;
    int         fails = 0;
    int         samples_checked = 0;
    always #2.5 core_clk = ~core_clk;
    flash_power_mode_control #(.SLEEP_DLY(SDLY), .WAKE_DLY(WDLY),
        .POWERUP_DLY(PUD), .SELECT_DLY(SELD)) u_flash_power_mode_control (
        .core_clk(core_clk), .rst_b(rst_b), .select_b(select_b),
        .serial_clk(serial_clk), .serial_in_line(serial_in_line),
        .cycle_done(cyc_done), .cycle_start(cyc_start),
        .write_permit_cmd(wp_cmd), .write_permit_clear(wp_clr),
        .deep_sleep(deep_sleep), .write_cycle_active(wca),
        .write_permit_latch(wpl), .writes_allowed(wr_ok),
        .reads_allowed(rd_ok), .cmd_accept(cmd_accept),
        .status_value(status_value), .erased_value(erased_value),
        .lock_bits(lock_bits));
    spi_host_model u_spi_host_model (.select_b(select_b),
        .serial_clk(serial_clk), .serial_in_line(serial_in_line));
    // Helpers driven at the falling edge
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse
    // Send a frame, give it time to settle, check the sleep flag
    task automatic try_op(input logic [15:0] w, input int n, input logic e);
        u_spi_host_model.send(w, n);
        cyc(40);
        `CHK(deep_sleep, e)
    endtask : try_op
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    // Watchdog
    initial begin
        #200000;
        fails++;
        end_sim();
    end
    // Main sequence
    initial begin
        {rst_b, cyc_done, cyc_start, wp_cmd, wp_clr} = 5'h00;
        cyc(20);
        rst_b = 1'b1;
        `CHK(deep_sleep, 1'b0)
        `CHK(status_value, STATUS_RESET_VALUE)
        `CHK(erased_value, ARRAY_ERASED_VALUE)
        `CHK(lock_bits, {4{LOCK_RESET_VALUE}})
        `CHK(rd_ok, 1'b0)
        $display("test reset state done");
        cyc(SELD + 5);
        `CHK(rd_ok, 1'b1)
        `CHK(wr_ok, 1'b0)
        pulse(wp_cmd);
        cyc(2);
        `CHK(wpl, 1'b0)
        cyc(PUD);
        `CHK(wr_ok, 1'b1)
        pulse(wp_cmd);
        cyc(2);
        `CHK(status_value, 8'h02)
        $display("test write inhibit done");
        pulse(cyc_start);
        cyc(2);
        `CHK(wca, 1'b1)
        try_op({8'h00, SLEEP_OPCODE_DEFAULT}, 8, 1'b0);
        pulse(cyc_done);
        cyc(2);
        `CHK(wca, 1'b0)
        $display("test busy refusal done");
        try_op({9'h000, SLEEP_OPCODE_DEFAULT[7:1]}, 7, 1'b0);
        try_op({7'h00, SLEEP_OPCODE_DEFAULT, 1'b1}, 9, 1'b0);
        try_op({8'h00, WAKE_OPCODE_DEFAULT}, 8, 1'b0);
        pulse(wp_clr);
        u_spi_host_model.send({8'h00, SLEEP_OPCODE_DEFAULT}, 8);
        cyc(8);
        `CHK(deep_sleep, 1'b0)
        cyc(30);
        `CHK(deep_sleep, 1'b1)
        $display("test sleep entry done");
        pulse(wp_cmd);
        cyc(2);
        `CHK(wpl, 1'b0)
        `CHK(cmd_accept, 1'b0)
        try_op({8'h00, SLEEP_OPCODE_DEFAULT}, 8, 1'b1);
        try_op({7'h00, WAKE_OPCODE_DEFAULT, 1'b0}, 9, 1'b1);
        u_spi_host_model.send({8'h00, WAKE_OPCODE_DEFAULT}, 8);
        cyc(8);
        `CHK(deep_sleep, 1'b0)
        `CHK(cmd_accept, 1'b0)
        cyc(WDLY + 5);
        `CHK(cmd_accept, 1'b1)
        $display("test wake done");
        try_op({8'h00, SLEEP_OPCODE_DEFAULT}, 8, 1'b1);
        rst_b = 1'b0;
        cyc(2);
        `CHK(deep_sleep, 1'b0)
        `CHK(rd_ok, 1'b0)
        rst_b = 1'b1;
        cyc(2);
        `CHK(deep_sleep, 1'b0)
        $display("test reset in sleep done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
